// File: design/ehm_pkg.sv
// Shared constants, types and register map of the error history memory.
`default_nettype none
package ehm_pkg;
  localparam int EHM_DEPTH = 10;
  localparam int EHM_PTR_W = 4;
  localparam logic [15:0] EHM_CMD_ACTIVE = 16'h0001;
  localparam logic [15:0] EHM_NO_ENTRY = 16'h0000;
  localparam logic [2:0] EHM_PHASE_FIRST = 3'h2;
  localparam logic [2:0] EHM_PHASE_LAST = 3'h4;

  // Parameter addresses on the parameter port.
  localparam logic [15:0] EHM_ADDR_CLEAR = 16'h3B08;
  localparam logic [15:0] EHM_ADDR_REWIND = 16'h3B0A;
  localparam logic [15:0] EHM_ADDR_CODE = 16'h3C02;
  localparam logic [15:0] EHM_ADDR_CLASS = 16'h3C04;
  localparam logic [15:0] EHM_ADDR_QUAL = 16'h3C08;
  localparam logic [15:0] EHM_ADDR_TIME = 16'h3C0A;
  localparam logic [15:0] EHM_ADDR_MOTOR_I = 16'h3C12;
  localparam logic [15:0] EHM_ADDR_T_PROD = 16'h3C14;
  localparam logic [15:0] EHM_ADDR_T_STAGE = 16'h3C16;
  localparam logic [15:0] EHM_ADDR_VDC = 16'h3C18;
  localparam logic [15:0] EHM_ADDR_VEL = 16'h3C1A;
  localparam logic [15:0] EHM_ADDR_EN_CNT = 16'h3C1C;
  localparam logic [15:0] EHM_ADDR_EN_TIME = 16'h3C1E;
  localparam logic [15:0] EHM_ADDR_PWR_ON = 16'h3C20;
  localparam logic [15:0] EHM_ADDR_CLASS1 = 16'h3C30;
  localparam logic [15:0] EHM_ADDR_CLASS2 = 16'h3C32;

  // Error class encoding: 0 is a warning without response, 1 to 4 the classes.
  typedef enum logic [2:0] {
    EHM_CLS_WARN = 3'h0,
    EHM_CLS_1 = 3'h1,
    EHM_CLS_2 = 3'h2,
    EHM_CLS_3 = 3'h3,
    EHM_CLS_4 = 3'h4
  } ehm_class_e;

  // One snapshot of drive quantities at error detection.
  typedef struct packed {
    ehm_class_e err_class;
    logic [15:0] err_code;
    logic [15:0] motor_current;
    logic [31:0] power_on_count;
    logic [15:0] add_info;
    logic [15:0] temp_product;
    logic [15:0] temp_stage;
    logic [31:0] detect_time;
    logic [15:0] dc_bus_voltage;
    logic [31:0] velocity;
    logic [15:0] enable_count;
    logic [31:0] time_since_enable;
  } ehm_entry_s;

  typedef ehm_entry_s [EHM_DEPTH-1:0] ehm_hist_t;

  // One parameter access from the fieldbus side.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } ehm_req_s;

  typedef enum logic [1:0] {
    EHM_OP_RUN,
    EHM_OP_QSTOP,
    EHM_OP_FAULT
  } ehm_op_e;
endpackage : ehm_pkg
`default_nettype wire

// File: design/ehm_store.sv
// History storage: ten snapshots, oldest at index zero, shift-out when full.
`default_nettype none
module ehm_store #(
  parameter int DEPTH = ehm_pkg::EHM_DEPTH
) (
  input wire logic clk_i,
  input wire logic capture_i,
  input wire ehm_pkg::ehm_entry_s snap_i,
  input wire logic clear_i,
  output ehm_pkg::ehm_hist_t hist_o,
  output logic [ehm_pkg::EHM_PTR_W-1:0] count_o
);
  import ehm_pkg::*;

  typedef struct packed {
    ehm_hist_t hist;
    logic [EHM_PTR_W-1:0] count;
  } ehm_store_s;

  ehm_store_s st_r;
  ehm_store_s st_nxt;

  // Clear runs first so a capture in the same cycle lands in an empty memory.
  always_comb begin
    st_nxt = st_r;
    if (clear_i) begin
      st_nxt.count = '0;
    end
    if (capture_i) begin
      if (st_nxt.count == EHM_PTR_W'(DEPTH)) begin
        for (int i = 0; i < DEPTH - 1; i++) begin
          st_nxt.hist[i] = st_nxt.hist[i+1];
        end
        st_nxt.hist[DEPTH-1] = snap_i;
      end else begin
        st_nxt.hist[st_nxt.count] = snap_i;
        st_nxt.count = st_nxt.count + 1'b1;
      end
    end
  end

  // No reset on purpose: the history must survive a reset like a power cycle.
  always_ff @(posedge clk_i) begin
    st_r <= st_nxt;
  end

  assign hist_o = st_r.hist;
  assign count_o = st_r.count;
endmodule : ehm_store
`default_nettype wire

// File: design/ehm_top.sv
// Error history memory with parameter port, read pointer and diagnostic words.
`default_nettype none
module ehm_top #(
  parameter int DEPTH = ehm_pkg::EHM_DEPTH
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire ehm_pkg::ehm_req_s req_i,
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  input wire logic [2:0] comm_phase_i,
  input wire logic err_detect_i,
  input wire ehm_pkg::ehm_entry_s err_snap_i,
  input wire logic [15:0] class1_diag_word_i,
  input wire logic [15:0] class2_diag_word_i,
  input wire logic qstop_done_i,
  input wire logic fault_reset_i,
  output logic quick_stop_o,
  output logic fault_o
);
  import ehm_pkg::*;

  typedef struct packed {
    logic [EHM_PTR_W-1:0] ptr;
    ehm_entry_s buffer;
    logic [31:0] rdata;
    logic rvalid;
    logic clear_busy;
    ehm_op_e op;
  } ehm_state_s;

  ehm_state_s st_r;
  ehm_state_s st_nxt;
  ehm_hist_t hist;
  logic [EHM_PTR_W-1:0] count;
  logic phase_ok;
  logic clear_cmd;
  logic rewind_cmd;
  logic code_read;
  logic have_entry;

  // Commands only count in the phases where the master may change parameters.
  assign phase_ok = (comm_phase_i >= EHM_PHASE_FIRST) && (comm_phase_i <= EHM_PHASE_LAST);
  assign clear_cmd = req_i.wr && phase_ok && (req_i.addr == EHM_ADDR_CLEAR)
                     && (req_i.wdata == EHM_CMD_ACTIVE);
  assign rewind_cmd = req_i.wr && phase_ok && (req_i.addr == EHM_ADDR_REWIND)
                      && (req_i.wdata == EHM_CMD_ACTIVE);
  assign code_read = req_i.rd && (req_i.addr == EHM_ADDR_CODE);
  assign have_entry = st_r.ptr < count;

  ehm_store #(
    .DEPTH(DEPTH)
  ) u_store (
    .clk_i(clk_i),
    .capture_i(err_detect_i),
    .snap_i(err_snap_i),
    .clear_i(clear_cmd),
    .hist_o(hist),
    .count_o(count)
  );

  // Pointer, entry buffer, read data and drive operating state.
  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = req_i.rd;
    st_nxt.rdata = '0;
    st_nxt.clear_busy = clear_cmd;
    if (rewind_cmd || clear_cmd) begin
      st_nxt.ptr = '0;
    end
    // One access per cycle, so a read never meets a command write in the same cycle.
    if (req_i.rd) begin
      unique case (req_i.addr)
        EHM_ADDR_CODE: begin
          if (have_entry) begin
            st_nxt.buffer = hist[st_r.ptr];
            st_nxt.rdata = {16'h0000, hist[st_r.ptr].err_code};
            st_nxt.ptr = st_r.ptr + 1'b1;
          end else begin
            // The pointer parks past the newest entry, so later reads keep answering zero.
            st_nxt.buffer = '0;
            st_nxt.rdata = {16'h0000, EHM_NO_ENTRY};
          end
        end
        EHM_ADDR_CLEAR: st_nxt.rdata = {31'h0, st_r.clear_busy};
        EHM_ADDR_CLASS: st_nxt.rdata = {29'h0, st_r.buffer.err_class};
        EHM_ADDR_QUAL: st_nxt.rdata = {16'h0000, st_r.buffer.add_info};
        EHM_ADDR_TIME: st_nxt.rdata = st_r.buffer.detect_time;
        EHM_ADDR_MOTOR_I: st_nxt.rdata = {16'h0000, st_r.buffer.motor_current};
        EHM_ADDR_T_PROD: st_nxt.rdata = {16'h0000, st_r.buffer.temp_product};
        EHM_ADDR_T_STAGE: st_nxt.rdata = {16'h0000, st_r.buffer.temp_stage};
        EHM_ADDR_VDC: st_nxt.rdata = {16'h0000, st_r.buffer.dc_bus_voltage};
        EHM_ADDR_VEL: st_nxt.rdata = st_r.buffer.velocity;
        EHM_ADDR_EN_CNT: st_nxt.rdata = {16'h0000, st_r.buffer.enable_count};
        EHM_ADDR_EN_TIME: st_nxt.rdata = st_r.buffer.time_since_enable;
        EHM_ADDR_PWR_ON: st_nxt.rdata = st_r.buffer.power_on_count;
        EHM_ADDR_CLASS1: st_nxt.rdata = {16'h0000, class1_diag_word_i};
        EHM_ADDR_CLASS2: st_nxt.rdata = {16'h0000, class2_diag_word_i};
        default: st_nxt.rdata = '0;
      endcase
    end
    // A class 1 error always drives the axis through quick stop into Fault.
    unique case (st_r.op)
      EHM_OP_RUN: begin
        if (class1_diag_word_i != 16'h0000) begin
          st_nxt.op = EHM_OP_QSTOP;
        end
      end
      EHM_OP_QSTOP: begin
        if (qstop_done_i) begin
          st_nxt.op = EHM_OP_FAULT;
        end
      end
      EHM_OP_FAULT: begin
        if (fault_reset_i && (class1_diag_word_i == 16'h0000)) begin
          st_nxt.op = EHM_OP_RUN;
        end
      end
      default: st_nxt.op = EHM_OP_FAULT;
    endcase
  end

  // Reset clears pointer, entry buffer, read data and drive state; the history itself lives on in the store.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o = st_r.rdata;
  assign rvalid_o = st_r.rvalid;
  assign quick_stop_o = (st_r.op == EHM_OP_QSTOP);
  assign fault_o = (st_r.op == EHM_OP_FAULT);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  // Read pointer: a code read with an entry left moves it on by one, rewind and clear bring it home.
  // The store is not reset, so its fill count must be known before these are enabled.
  a_code_read_adv: assert property (
    code_read && have_entry && !rewind_cmd && !clear_cmd |=> st_r.ptr == $past(st_r.ptr) + 1'b1)
    else $error("Read pointer did not advance after a code read.");
  a_rewind_to_old: assert property (rewind_cmd |=> st_r.ptr == '0)
    else $error("Rewind did not return the pointer to the oldest entry.");
  a_clear_ptr: assert property (
    clear_cmd && !err_detect_i |=> st_r.ptr == '0 && !have_entry)
    else $error("Clear left an entry readable.");
  a_end_reads_zero: assert property (code_read && !have_entry |=> rvalid_o && rdata_o == 32'h0)
    else $error("End of history did not read as code zero.");

  // Field reads come from the latched copy, so a capture between two field reads
  // cannot tear one entry into parts of two.
  a_buffer_latch: assert property (
    code_read && have_entry && !err_detect_i && !clear_cmd |=> st_r.buffer == hist[$past(st_r.ptr)])
    else $error("Entry buffer does not hold the entry that was read.");
  a_field_from_buf: assert property (
    req_i.rd && req_i.addr == EHM_ADDR_QUAL |=> rdata_o == {16'h0000, $past(st_r.buffer.add_info)})
    else $error("Field read did not come from the latched entry.");

  // A refused write must leave the pointer and the fill count alone, not only the strobes.
  a_phase_gate: assert property (
    req_i.wr && !req_i.rd && !phase_ok |=> st_r.ptr == $past(st_r.ptr))
    else $error("Rewind accepted outside phases two to four.");
  a_phase_keep: assert property (
    req_i.wr && !phase_ok && !err_detect_i |=> count == $past(count))
    else $error("Clear accepted outside phases two to four.");
  a_clear_empties: assert property (clear_cmd && !err_detect_i |=> count == '0 ##1 !st_r.clear_busy)
    else $error("Clear did not empty the history in time.");

  // Store fill: append until full, then the newest always lands in the last slot.
  a_depth_limit: assert property (count <= EHM_PTR_W'(DEPTH))
    else $error("History holds more than its depth.");
  a_capture_count: assert property (
    err_detect_i && !clear_cmd && count < EHM_PTR_W'(DEPTH) |=> count == $past(count) + 1'b1)
    else $error("Capture did not append one entry.");
  a_full_newest: assert property (
    err_detect_i && !clear_cmd && count == EHM_PTR_W'(DEPTH) |=> hist[DEPTH-1] == $past(err_snap_i))
    else $error("Newest error is not at the last position.");

  // Drive state: quick stop, then Fault, and back to run only with a clean class 1 word.
  // The diagnostic words are passed through as they stand at the read edge.
  a_class1_stop: assert property (
    st_r.op == EHM_OP_RUN && class1_diag_word_i != 16'h0000 |=> quick_stop_o ##0 !fault_o)
    else $error("Class 1 error did not start a quick stop.");
  a_qstop_fault: assert property (quick_stop_o && qstop_done_i |=> fault_o && !quick_stop_o)
    else $error("Finished quick stop did not enter Fault.");
  a_fault_leave: assert property (
    fault_o && fault_reset_i && class1_diag_word_i == 16'h0000 |=> !fault_o && !quick_stop_o)
    else $error("Fault was not left on a reset request.");
  a_class2_echo: assert property (
    req_i.rd && req_i.addr == EHM_ADDR_CLASS2 |=> rdata_o == {16'h0000, $past(class2_diag_word_i)})
    else $error("Class 2 word read back wrong.");

  // Main scenarios: wrap of a full store, end of history, the fault path,
  // a read straight after a rewind and a write refused by the phase gate.
  c_full_wrap: cover property (err_detect_i && count == EHM_PTR_W'(DEPTH));
  c_end_of_hist: cover property (code_read && !have_entry && count != '0);
  c_fault_entry: cover property (quick_stop_o ##1 fault_o);
  c_rewind_read: cover property (rewind_cmd ##2 code_read);
  c_phase_refused: cover property (req_i.wr && !phase_ok);
endmodule : ehm_top
`default_nettype wire

// File: test/ehm_master.sv
// Fieldbus master model that issues parameter reads and writes.
`default_nettype none
module ehm_master (
  input wire logic clk_i,
  output ehm_pkg::ehm_req_s req_o,
  input wire logic [31:0] rdata_i,
  input wire logic rvalid_i
);
  timeunit 1ns;
  timeprecision 1ns;
  import ehm_pkg::*;

  initial req_o = '0;

  // One access; idle address and data are inverted so a stale value never passes for a request.
  task automatic xfer(input logic rd, input logic [15:0] a, input logic [15:0] d, output logic [31:0] q);
    @(posedge clk_i);
    req_o <= '{rd: rd, wr: !rd, addr: a, wdata: d};
    @(posedge clk_i);
    req_o <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    q = 32'h0;
    if (rd) begin
      @(posedge clk_i);
      q = rvalid_i ? rdata_i : 32'hFFFF_FFFF;
    end
  endtask : xfer
endmodule : ehm_master
`default_nettype wire

// File: test/error_history_memory_tb.sv
// Self-checking bench for the error history memory.
`default_nettype none
module error_history_memory_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ehm_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [2:0] phase = 3'h2;
  logic [15:0] c1 = 16'h0000;
  logic [15:0] c2 = 16'h0000;
  logic det, qdone, frst, qstop, fault, rvalid;
  logic [31:0] rdata;
  ehm_req_s req;
  ehm_entry_s snap;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;

  ehm_top #(.DEPTH(EHM_DEPTH)) uut (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(req), .rdata_o(rdata),
    .rvalid_o(rvalid), .comm_phase_i(phase), .err_detect_i(det), .err_snap_i(snap),
    .class1_diag_word_i(c1), .class2_diag_word_i(c2), .qstop_done_i(qdone), .fault_reset_i(frst),
    .quick_stop_o(qstop), .fault_o(fault));
  ehm_master mst (.clk_i(clk_i), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid));

  always #10 clk_i = ~clk_i;

  // A hang is cut short well beyond the few hundred cycles the run needs.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic rd(input logic [15:0] a, input logic [31:0] exp, input string name);
    logic [31:0] q;
    mst.xfer(1'b1, a, 16'h0000, q);
    chk(name, exp, q);
  endtask : rd

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    logic [31:0] q;
    mst.xfer(1'b0, a, d, q);
  endtask : wr

  // Snapshot fields are derived from the code so each entry is distinguishable.
  function automatic ehm_entry_s mk(input logic [15:0] c);
    ehm_entry_s s;
    s = '0;
    s.err_class = ehm_class_e'(3'(c % 16'h0005));
    s.err_code = c;
    s.motor_current = c ^ 16'h0A50;
    s.velocity = {c, ~c};
    s.power_on_count = {16'h1000, c};
    s.add_info = c + 16'h0100;
    s.temp_product = c ^ 16'h00F0;
    s.temp_stage = c ^ 16'h0F00;
    s.detect_time = {c, 16'h2000};
    s.dc_bus_voltage = c ^ 16'h3000;
    s.enable_count = c ^ 16'h4000;
    s.time_since_enable = {~c, c};
    return s;
  endfunction : mk

  // The snapshot moves on right after the detect pulse, so a late sample shows up.
  task automatic capture(input logic [15:0] c);
    @(posedge clk_i);
    snap <= mk(c);
    det <= 1'b1;
    @(posedge clk_i);
    snap <= mk(16'h7777);
    det <= 1'b0;
  endtask : capture

  // Code first, then fields taken from the latched entry.
  task automatic entry(input logic [15:0] c);
    rd(EHM_ADDR_CODE, {16'h0, c}, "code");
    rd(EHM_ADDR_CLASS, {29'h0, 3'(c % 16'h0005)}, "class");
    rd(EHM_ADDR_MOTOR_I, {16'h0, c ^ 16'h0A50}, "motor_current");
    rd(EHM_ADDR_VEL, {c, ~c}, "velocity");
    rd(EHM_ADDR_QUAL, {16'h0, c + 16'h0100}, "add_info");
    rd(EHM_ADDR_TIME, {c, 16'h2000}, "detect_time");
    rd(EHM_ADDR_T_PROD, {16'h0, c ^ 16'h00F0}, "temp_product");
    rd(EHM_ADDR_T_STAGE, {16'h0, c ^ 16'h0F00}, "temp_stage");
    rd(EHM_ADDR_VDC, {16'h0, c ^ 16'h3000}, "dc_bus_voltage");
    rd(EHM_ADDR_EN_CNT, {16'h0, c ^ 16'h4000}, "enable_count");
    rd(EHM_ADDR_EN_TIME, {~c, c}, "time_since_enable");
    rd(EHM_ADDR_PWR_ON, {16'h1000, c}, "power_on_count");
  endtask : entry

  initial begin
    det = 1'b0;
    qdone = 1'b0;
    frst = 1'b0;
    snap = '0;
    // The retained store powers up unknown, so it is emptied while reset still holds.
    repeat (2) @(posedge clk_i);
    wr(EHM_ADDR_CLEAR, EHM_CMD_ACTIVE);
    @(posedge clk_i);
    nrst_i <= 1'b1;
    wr(EHM_ADDR_CLEAR, EHM_CMD_ACTIVE);
    rd(EHM_ADDR_CLEAR, 32'h0, "clear_done");
    for (int i = 1; i <= 11; i++) capture(16'(i));
    wr(EHM_ADDR_REWIND, EHM_CMD_ACTIVE);
    for (int i = 2; i <= 11; i++) entry(16'(i));
    rd(EHM_ADDR_CODE, 32'h0, "end_code");
    rd(EHM_ADDR_CLASS, 32'h0, "end_class");
    // History must survive a reset in mid-run.
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    wr(EHM_ADDR_REWIND, EHM_CMD_ACTIVE);
    entry(16'h0002);
    phase <= 3'h1;
    wr(EHM_ADDR_REWIND, EHM_CMD_ACTIVE);
    rd(EHM_ADDR_CODE, 32'h3, "code_phase1");
    phase <= 3'h3;
    wr(EHM_ADDR_REWIND, EHM_CMD_ACTIVE);
    rd(EHM_ADDR_CODE, 32'h2, "code_rewound");
    phase <= 3'h0;
    wr(EHM_ADDR_CLEAR, EHM_CMD_ACTIVE);
    rd(EHM_ADDR_CODE, 32'h3, "code_kept");
    phase <= 3'h4;
    wr(EHM_ADDR_CLEAR, EHM_CMD_ACTIVE);
    rd(EHM_ADDR_CODE, 32'h0, "code_cleared");
    c2 <= 16'h0A5C;
    rd(EHM_ADDR_CLASS2, 32'h0000_0A5C, "class2_word");
    wr(EHM_ADDR_CLASS1, 16'h1234);
    c1 <= 16'h0008;
    repeat (2) @(posedge clk_i);
    chk("quick_stop", 32'h1, {31'h0, qstop});
    qdone <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("fault", 32'h1, {31'h0, fault});
    rd(EHM_ADDR_CLASS1, 32'h0000_0008, "class1_word");
    c1 <= 16'h0000;
    frst <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("fault_left", 32'h0, {31'h0, fault});
    give_verdict();
  end
endmodule : error_history_memory_tb
`default_nettype wire
